// *** rtl/fps_pkg.sv ***
// Constants and layout of the flash programming setup registers
package fps_pkg;
   // -----------------------------------------
   // Register offsets
   // -----------------------------------------
   localparam logic [19:0] OFS_MODE_CTRL = 20'hF02C0;
   localparam logic [19:0] OFS_START_LOW = 20'hF02C2;
   localparam logic [19:0] OFS_START_HIGH = 20'hF02C4;
   localparam logic [19:0] OFS_END = 20'hF02C8;
   localparam logic [19:0] OFS_WBUF_LOW = 20'hF02CA;
   localparam logic [19:0] OFS_WBUF_HIGH = 20'hF02CC;
   // -----------------------------------------
   // Fields and reset values
   // -----------------------------------------
   localparam int BIT_DATA_MODE = 4;
   localparam int BIT_CODE_INHIBIT = 3;
   localparam int BIT_CODE_MODE = 1;
   localparam logic [7:0] MODE_CTRL_WMASK = 8'h1A;
   localparam logic [7:0] MODE_CTRL_RESET = 8'h08;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [3:0] HIGH_RESET = 4'h0;
endpackage

// *** rtl/fps_buf_if.sv ***
// Carrier between the setup block and one write buffer word
`timescale 1ns/1ps
interface fps_buf_if;
   logic clear;
   logic load;
   logic [15:0] din;
   logic [15:0] q;
   modport owner (input clear, input load, input din, output q);
   modport user (output clear, output load, output din, input q);
endinterface

// *** rtl/fps_word_buf.sv ***
// One 16-bit write buffer word with clear priority over load
`timescale 1ns/1ps
module fps_word_buf
   import fps_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control and data
   fps_buf_if.owner bus
);
   typedef struct packed {
      logic [15:0] word;
   } fps_wbuf_state_t;

   fps_wbuf_state_t state_reg;
   fps_wbuf_state_t state_next;

   always_comb begin
      state_next = state_reg;
      // A clear in the same cycle as a load wins; stale data must never survive
      if (bus.clear) begin
         state_next.word = WORD_RESET;
      end else if (bus.load) begin
         state_next.word = bus.din;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus.q = state_reg.word;
endmodule

// *** rtl/fps_setup_regs.sv ***
// Flash programming setup registers: mode control, address pointers, write buffers
`timescale 1ns/1ps
module fps_setup_regs
   import fps_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic [19:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic regWide,
   input wire logic [15:0] regWdata,
   output logic [15:0] regRdata,
   // Sequencer status
   input wire logic extraSeqEnd,
   input wire logic areaSeqEnd,
   input wire logic seqFinish,
   input wire logic flashSoftReset,
   // Setup toward the sequencer
   output logic [19:0] startAddr,
   output logic [19:0] endAddr,
   output logic [31:0] writeData,
   output logic codeProgMode,
   output logic dataProgMode,
   output logic codeEraseInhibit
);
   // -----------------------------------------
   // State
   // -----------------------------------------
   typedef struct packed {
      logic [7:0] modeCtrl;
      logic [3:0] startHigh;
      logic [15:0] startLow;
      logic [3:0] endHigh;
      logic [15:0] endLow;
      logic [19:0] endEff;
      logic [15:0] rdata;
   } fps_state_t;

   fps_state_t state_reg;
   fps_state_t state_next;

   fps_buf_if bufLow ();
   fps_buf_if bufHigh ();

   logic stopped;
   logic progOk;
   logic gateOk;
   logic wr8;
   logic wr16;

   // -----------------------------------------
   // Decode
   // -----------------------------------------
   always_comb begin
      stopped = !extraSeqEnd && !areaSeqEnd;
      progOk = state_reg.modeCtrl[BIT_CODE_MODE] || state_reg.modeCtrl[BIT_DATA_MODE];
      // Gated writes are dropped silently; there is no error flag to report them
      gateOk = stopped && progOk;
      wr8 = regWr && !regWide;
      wr16 = regWr && regWide;
   end

   always_comb begin
      bufLow.clear = seqFinish || flashSoftReset;
      bufHigh.clear = seqFinish || flashSoftReset;
      bufLow.load = wr16 && gateOk && (regAddr == OFS_WBUF_LOW);
      bufHigh.load = wr16 && gateOk && (regAddr == OFS_WBUF_HIGH);
      bufLow.din = regWdata;
      bufHigh.din = regWdata;
   end

   fps_word_buf u_buf_low (
      .clk(clk),
      .rst(rst),
      .bus(bufLow.owner)
   );

   fps_word_buf u_buf_high (
      .clk(clk),
      .rst(rst),
      .bus(bufHigh.owner)
   );

   // -----------------------------------------
   // Next state
   // -----------------------------------------
   always_comb begin
      state_next = state_reg;
      // Mode control may change only while both sequencers are stopped
      if (wr8 && stopped && (regAddr == OFS_MODE_CTRL)) begin
         state_next.modeCtrl = regWdata[7:0] & MODE_CTRL_WMASK;
      end
      if (wr16 && gateOk && (regAddr == OFS_START_LOW)) begin
         state_next.startLow = regWdata;
      end
      if (wr8 && gateOk && (regAddr == OFS_START_HIGH)) begin
         state_next.startHigh = regWdata[3:0];
      end
      // Both end halves share one offset; the access width picks the half
      if (wr16 && gateOk && (regAddr == OFS_END)) begin
         state_next.endLow = regWdata;
      end
      if (wr8 && gateOk && (regAddr == OFS_END)) begin
         state_next.endHigh = regWdata[3:0];
      end
      state_next.endEff = {state_next.endHigh, state_next.endLow};
      if (state_next.modeCtrl[BIT_CODE_MODE]) begin
         state_next.endEff[1:0] = 2'h0;
      end
      // Reads while a sequencer runs return zero rather than live values
      if (regRd && stopped) begin
         unique case ({regWide, regAddr})
            {1'b0, OFS_MODE_CTRL}: state_next.rdata = {8'h00, state_reg.modeCtrl};
            {1'b1, OFS_START_LOW}: state_next.rdata = state_reg.startLow;
            {1'b0, OFS_START_HIGH}: state_next.rdata = {12'h000, state_reg.startHigh};
            {1'b1, OFS_END}: state_next.rdata = state_reg.endLow;
            {1'b0, OFS_END}: state_next.rdata = {12'h000, state_reg.endHigh};
            {1'b1, OFS_WBUF_LOW}: state_next.rdata = bufLow.q;
            {1'b1, OFS_WBUF_HIGH}: state_next.rdata = bufHigh.q;
            default: state_next.rdata = 16'h0000;
         endcase
      end else if (regRd) begin
         state_next.rdata = 16'h0000;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.modeCtrl <= MODE_CTRL_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // -----------------------------------------
   // Outputs
   // -----------------------------------------
   assign regRdata = state_reg.rdata;
   assign startAddr = {state_reg.startHigh, state_reg.startLow};
   assign endAddr = state_reg.endEff;
   assign writeData = {bufHigh.q, bufLow.q};
   assign codeProgMode = state_reg.modeCtrl[BIT_CODE_MODE];
   assign dataProgMode = state_reg.modeCtrl[BIT_DATA_MODE];
   assign codeEraseInhibit = state_reg.modeCtrl[BIT_CODE_INHIBIT];

   // -----------------------------------------
   // Checks
   // -----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_mode_reset: assert property ($fell(rst) |-> codeEraseInhibit && !codeProgMode
      && !dataProgMode) else $error("mode control not 08h after reset");
   chk_start_load: assert property (wr16 && gateOk && regAddr == OFS_START_LOW
      |=> startAddr[15:0] == $past(regWdata)) else $error("start low not loaded");
   chk_start_gated: assert property (regWr && !gateOk && !(wr16 && regAddr == OFS_END)
      && !(wr8 && regAddr == OFS_END) |=> $stable(startAddr)) else $error("start changed");
   // A mode write may legally change the code mode mask, so it is left out here
   chk_end_gated: assert property (regWr && !progOk && regAddr != OFS_MODE_CTRL
      |=> $stable(endAddr)) else $error("end address changed outside programming mode");
   chk_end_mask: assert property (codeProgMode |-> endAddr[1:0] == 2'h0)
      else $error("end address low bits kept in code mode");
   chk_high_zero: assert property (regRd && !regWide && regAddr == OFS_START_HIGH
      |=> regRdata[15:4] == 12'h000) else $error("start high upper bits not zero");
   chk_buf_clear: assert property (seqFinish || flashSoftReset
      |=> writeData == 32'h00000000) else $error("write buffer not cleared");
   chk_buf_gated: assert property (regWr && !gateOk && !seqFinish && !flashSoftReset
      |=> $stable(writeData)) else $error("write buffer changed while gated");
   chk_buf_load: assert property (wr16 && gateOk && regAddr == OFS_WBUF_HIGH && !seqFinish
      && !flashSoftReset |=> writeData[31:16] == $past(regWdata)) else $error("buffer high");
   chk_busy_hold: assert property (!stopped && regWr |=> $stable(startAddr)
      && $stable(dataProgMode) && $stable(codeProgMode)
      && ($stable(writeData[15:0]) || $past(seqFinish) || $past(flashSoftReset)))
      else $error("setup changed while sequencer running");

   cov_code_mode: cover property (wr8 && regAddr == OFS_MODE_CTRL ##1 codeProgMode);
   cov_buf_write: cover property (bufLow.load ##2 bufHigh.load ##[1:8] seqFinish);
   cov_end_split: cover property (wr8 && gateOk && regAddr == OFS_END ##2 wr16 && gateOk);
   cov_busy_drop: cover property (regWr && !stopped && progOk);
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the flash programming setup registers
`timescale 1ns/1ps
module tb_top
   import fps_pkg::*;
;
   // --------------------------------
   // Stimulus and observed signals
   // --------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [19:0] regAddr = 20'h00000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic regWide = 1'b0;
   logic [15:0] regWdata = 16'h0000;
   logic [15:0] regRdata;
   logic extraSeqEnd = 1'b0;
   logic areaSeqEnd = 1'b0;
   logic seqFinish = 1'b0;
   logic flashSoftReset = 1'b0;
   logic [19:0] startAddr;
   logic [19:0] endAddr;
   logic [31:0] writeData;
   logic codeProgMode;
   logic dataProgMode;
   logic codeEraseInhibit;
   int errors = 0;
   int n_compared = 0;

   always #25 clk = ~clk;

   fps_setup_regs uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
      .regWide(regWide), .regWdata(regWdata), .regRdata(regRdata), .extraSeqEnd(extraSeqEnd),
      .areaSeqEnd(areaSeqEnd), .seqFinish(seqFinish), .flashSoftReset(flashSoftReset),
      .startAddr(startAddr), .endAddr(endAddr), .writeData(writeData),
      .codeProgMode(codeProgMode), .dataProgMode(dataProgMode),
      .codeEraseInhibit(codeEraseInhibit));

   // --------------------------------
   // Access tasks
   // --------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Strobe is one cycle; a write shows on the outputs right after its edge
   task automatic wr(input logic [19:0] a, input logic w, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWide <= w;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [19:0] a, input logic w, input logic [15:0] e, input string s);
      @(posedge clk);
      regAddr <= a;
      regWide <= w;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      check({16'h0000, regRdata}, {16'h0000, e}, s);
   endtask

   // Clear source: finish pulse when fin is 1, one-cycle soft reset pulse otherwise
   task automatic pulse(input logic fin);
      @(posedge clk);
      if (fin) seqFinish <= 1'b1;
      else flashSoftReset <= 1'b1;
      @(posedge clk);
      seqFinish <= 1'b0;
      flashSoftReset <= 1'b0;
      #1;
   endtask

   task automatic close_out;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // --------------------------------
   // Watchdog
   // --------------------------------
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("mismatch at %0t: run did not finish", $time);
      close_out();
   end

   // --------------------------------
   // Scenarios
   // --------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_MODE_CTRL, 1'b0, 16'h0008, "mode reset");
      check({31'h0, codeEraseInhibit}, 32'h1, "inhibit reset");
      rd(OFS_WBUF_LOW, 1'b1, 16'h0000, "buffer reset");
      // Nothing gated may land before a programming mode is chosen
      wr(OFS_START_LOW, 1'b1, 16'h1234);
      rd(OFS_START_LOW, 1'b1, 16'h0000, "start gated");
      wr(OFS_END, 1'b1, 16'h1234);
      check({12'h0, endAddr}, 32'h0, "end gated");
      wr(OFS_WBUF_LOW, 1'b1, 16'h1234);
      check(writeData, 32'h0, "buffer gated");
      wr(OFS_MODE_CTRL, 1'b0, 16'h00FF);
      rd(OFS_MODE_CTRL, 1'b0, 16'h001A, "mode writable bits");
      wr(OFS_MODE_CTRL, 1'b0, 16'h0012);
      check({29'h0, codeProgMode, dataProgMode, codeEraseInhibit}, 32'h6, "modes");
      wr(OFS_START_HIGH, 1'b0, 16'h00FF);
      wr(OFS_START_LOW, 1'b1, 16'hABCD);
      check({12'h0, startAddr}, 32'hFABCD, "start pointer");
      rd(OFS_START_HIGH, 1'b0, 16'h000F, "start high upper bits");
      wr(OFS_END, 1'b0, 16'h00F5);
      wr(OFS_END, 1'b1, 16'h1237);
      check({12'h0, endAddr}, 32'h51234, "end masked in code mode");
      rd(OFS_END, 1'b0, 16'h0005, "end high");
      wr(OFS_MODE_CTRL, 1'b0, 16'h0010);
      check({12'h0, endAddr}, 32'h51237, "end full in data mode");
      wr(OFS_WBUF_LOW, 1'b1, 16'h00A5);
      wr(OFS_WBUF_HIGH, 1'b1, 16'h5A5A);
      check(writeData, 32'h5A5A00A5, "buffer pair");
      wr(OFS_WBUF_LOW, 1'b0, 16'h00FF);
      check(writeData, 32'h5A5A00A5, "narrow buffer write");
      rd(OFS_WBUF_HIGH, 1'b1, 16'h5A5A, "buffer high read");
      pulse(1'b1);
      check(writeData, 32'h0, "clear on finish");
      // Data byte alone in the low buffer, as software must do in data mode
      wr(OFS_WBUF_LOW, 1'b1, 16'h00C3);
      check(writeData, 32'h000000C3, "buffer before soft reset");
      pulse(1'b0);
      check(writeData, 32'h0, "clear on soft reset");
      // Each busy flag alone must freeze every setup register
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         areaSeqEnd <= (i == 0);
         extraSeqEnd <= (i == 1);
         wr(OFS_START_LOW, 1'b1, 16'h1111);
         wr(OFS_WBUF_LOW, 1'b1, 16'h7777);
         wr(OFS_MODE_CTRL, 1'b0, 16'h0002);
         rd(OFS_START_LOW, 1'b1, 16'h0000, "read while busy");
         check({12'h0, startAddr}, 32'hFABCD, "start while busy");
         check(writeData, 32'h0, "buffer while busy");
         check({31'h0, dataProgMode}, 32'h1, "mode while busy");
      end
      @(posedge clk);
      extraSeqEnd <= 1'b0;
      wr(OFS_MODE_CTRL, 1'b0, 16'h0002);
      wr(OFS_WBUF_LOW, 1'b1, 16'h9999);
      check(writeData, 32'h00009999, "code mode alone opens buffer");
      wr(OFS_MODE_CTRL, 1'b0, 16'h0008);
      wr(OFS_WBUF_HIGH, 1'b1, 16'h4444);
      wr(OFS_START_HIGH, 1'b0, 16'h0001);
      check(writeData, 32'h00009999, "buffer after mode off");
      check({12'h0, startAddr}, 32'hFABCD, "start after mode off");
      rd(20'hF02CE, 1'b1, 16'h0000, "unmapped read");
      close_out();
   end
endmodule
